// File: tpg_pkg.sv
// Shared constants and types for the two-port GPIO block
package tpg_pkg;

  // Word indices; byte address is four times the index
  localparam logic [31:0] IDX_WIDE_LATCH   = 32'hFFFFF005;
  localparam logic [31:0] IDX_WIDE_DIR     = 32'hFFFFF025;
  localparam logic [31:0] IDX_NARROW_DIR   = 32'hFFFFF02C;
  localparam logic [31:0] IDX_NARROW_FSEL  = 32'hFFFFF04C;
  localparam logic [31:0] IDX_NARROW_LATCH = 32'hFFFFF00C;
  localparam logic [31:0] IDX_DEBUG_MODE   = 32'hFFFFF9FC;
  localparam logic [31:0] IDX_BIT_OP       = 32'hFFFFF0FC;

  // Reset values
  localparam logic [7:0] RST_LATCH = 8'h00;
  localparam logic [7:0] RST_DIR   = 8'hFF;
  localparam logic [7:0] RST_FSEL  = 8'h00;
  localparam logic       RST_DEBUG = 1'b1;

  // Implemented-bit masks and fixed values of unimplemented bits
  localparam logic [7:0] NARROW_MASK = 8'h03;
  localparam logic [7:0] FSEL_MASK   = 8'h02;
  localparam logic [7:0] WIDE_MASK   = 8'hFF;
  localparam logic [7:0] DIR_FIXED   = 8'hFC;
  localparam logic [7:0] ZERO_FIXED  = 8'h00;

  // Field positions
  localparam int unsigned FSEL_CLK_BIT   = 1;
  localparam int unsigned DEBUG_MODE_BIT = 0;
  localparam int unsigned BITOP_BIT_LSB  = 0;
  localparam int unsigned BITOP_VAL_POS  = 4;
  localparam int unsigned BITOP_TGT_LSB  = 8;

  // Targets of a single-bit operation, in field-code order
  typedef enum logic [2:0] {
    TGT_NARROW_LATCH,
    TGT_NARROW_DIR,
    TGT_NARROW_FSEL,
    TGT_WIDE_LATCH,
    TGT_WIDE_DIR,
    TGT_DEBUG,
    TGT_NONE6,
    TGT_NONE7
  } tpg_target_t;

  // Classic Wishbone request from the master
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [31:0] adr;
    logic [31:0] dat;
  } tpg_wb_req_t;

endpackage

// File: tpg_port.sv
// One GPIO port slice: registered pin drive and read-back selection
`timescale 1ns/1ps
`default_nettype none
module tpg_port #(
  parameter int unsigned W = 8
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] latch_i,
  input  wire logic [W-1:0] dir_i,
  input  wire logic [W-1:0] alt_en_i,
  input  wire logic [W-1:0] alt_val_i,
  input  wire logic [W-1:0] pin_i,
  output var  logic [W-1:0] pin_o,
  output var  logic [W-1:0] pin_oe_o,
  output wire logic [W-1:0] rd_o
);

  wire [W-1:0] next_pin_o;
  wire [W-1:0] next_pin_oe;

  // (RULE3) latch bit drives level
  assign next_pin_o  = (alt_en_i & alt_val_i) | (~alt_en_i & latch_i);
  // (RULE4) zero means output
  assign next_pin_oe = alt_en_i | ~dir_i;

  // (RULE1) input reads pin, (RULE2) output reads latch
  assign rd_o = (dir_i & pin_i) | (~dir_i & latch_i);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_o    <= '0;
      pin_oe_o <= '0;
    end else begin
      // (RULE2) new value driven next edge
      pin_o    <= next_pin_o;
      pin_oe_o <= next_pin_oe;
    end
  end

endmodule
`default_nettype wire

// File: tpg_debug.sv
// Debug-mode enable bit controlling the shared debug pins
`timescale 1ns/1ps
`default_nettype none
module tpg_debug (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic clear_i,
  output var  logic mode_o,
  output var  logic sel_o,
  output var  logic pulldown_en_o
);

  logic next_mode;

  // Only reset sets the bit; software can only clear it
  assign next_mode = mode_o & ~clear_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      // (RULE10) debug pins after reset
      mode_o        <= tpg_pkg::RST_DEBUG;
      sel_o         <= tpg_pkg::RST_DEBUG;
      // (RULE13) pull-down on after reset
      pulldown_en_o <= tpg_pkg::RST_DEBUG;
    end else begin
      mode_o        <= next_mode;
      // (RULE11) port use once cleared
      sel_o         <= next_mode;
      // (RULE13) pull-down off once cleared
      pulldown_en_o <= next_mode;
    end
  end

endmodule
`default_nettype wire

// File: tpg_gpio.sv
// Two-port GPIO with debug-pin control behind a classic Wishbone slave
//
// Contract
// (RULE1) An input-mode pin reads back its pin level, and a write only updates its latch.
// (RULE2) An output-mode pin reads back its latch, and a write drives the new value out.
// (RULE3) In output mode a latch 0 drives low and a 1 drives high, bit by bit.
// (RULE4) Narrow direction bits mean output at 0, input at 1, and reset to all ones.
// (RULE5) Narrow function bit 1 routes pin 1 to the clock output when 1, resets to zero.
// (RULE6) After reset the narrow latch reads zero in output mode, pin level in input mode.
// (RULE7) The wide port has eight pins, same direction coding, direction resets to ones.
// (RULE8) The wide latch is cleared at reset so an output-mode read returns zero.
// (RULE9) All latch, direction and function registers take byte and single-bit writes.
// (RULE10) After reset the five shared pins serve the debug functions.
// (RULE11) The shared pins return to port use once software clears the debug-mode bit.
// (RULE12) Outside, the debug reset pin is held low until the debug-mode bit is cleared.
// (RULE13) The debug reset pull-down is on after reset and off once the bit is cleared.
// (RULE14) With the debug reset pin kept low, software may leave the debug-mode bit set.
// (RULE15) Wide pin 5 needs no register handling for flash programming.
// (RULE16) Unimplemented bits read fixed values and ignore writes.
`timescale 1ns/1ps
`default_nettype none
module tpg_gpio #(
  parameter int unsigned NARROW_W = 2,
  parameter int unsigned WIDE_W   = 8
) (
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire tpg_pkg::tpg_wb_req_t wb_req_i,
  output var  logic [31:0]          wb_dat_o,
  output var  logic                 wb_ack_o,
  input  wire logic [NARROW_W-1:0]  narrow_pin_i,
  output wire logic [NARROW_W-1:0]  narrow_pin_o,
  output wire logic [NARROW_W-1:0]  narrow_pin_oe_o,
  input  wire logic                 clock_output_function_i,
  input  wire logic [WIDE_W-1:0]    wide_pin_i,
  output wire logic [WIDE_W-1:0]    wide_pin_o,
  output wire logic [WIDE_W-1:0]    wide_pin_oe_o,
  output wire logic                 debug_pins_sel_o,
  output wire logic                 debug_reset_pulldown_en_o
);

  // Word-address match against a register index
  function automatic logic hit(
    input logic [31:0] adr,
    input logic [31:0] idx
  );
    hit = (adr[31:2] == idx[29:0]);
  endfunction

  // Byte or single-bit update, then force unimplemented bits
  function automatic logic [7:0] upd(
    input logic [7:0] old,
    input logic       byte_wr,
    input logic [7:0] wdata,
    input logic       bit_wr,
    input logic [2:0] bitnum,
    input logic       bitval,
    input logic [7:0] mask,
    input logic [7:0] fixed
  );
    logic [7:0] v;
    v = old;
    if (byte_wr) begin
      v = wdata;
    end else if (bit_wr) begin
      v[bitnum] = bitval;
    end
    upd = (v & mask) | (fixed & ~mask);
  endfunction

  // Registers
  logic [7:0] narrow_latch;
  logic [7:0] narrow_port_direction;
  logic [7:0] narrow_port_function_select;
  logic [7:0] wide_port_latch;
  logic [7:0] wide_port_direction;

  // Bus handshake
  wire req;
  wire take;
  wire commit;
  wire byte_wr;
  wire bit_op_wr;

  assign req     = wb_req_i.cyc & wb_req_i.stb;
  assign take    = req & ~wb_ack_o;
  // Writes land on the edge where the master sees ack
  assign commit  = req & wb_ack_o & wb_req_i.we;
  // (RULE9) byte access on lane 0
  wire byte_lane;
  assign byte_lane = wb_req_i.sel[0];
  assign byte_wr   = commit & byte_lane;

  // Address decode
  wire hit_nl;
  wire hit_nd;
  wire hit_nf;
  wire hit_wl;
  wire hit_wd;
  wire hit_dbg;
  wire hit_bop;
  wire hit_any;

  assign hit_nl  = hit(wb_req_i.adr, tpg_pkg::IDX_NARROW_LATCH);
  assign hit_nd  = hit(wb_req_i.adr, tpg_pkg::IDX_NARROW_DIR);
  assign hit_nf  = hit(wb_req_i.adr, tpg_pkg::IDX_NARROW_FSEL);
  assign hit_wl  = hit(wb_req_i.adr, tpg_pkg::IDX_WIDE_LATCH);
  assign hit_wd  = hit(wb_req_i.adr, tpg_pkg::IDX_WIDE_DIR);
  assign hit_dbg = hit(wb_req_i.adr, tpg_pkg::IDX_DEBUG_MODE);
  assign hit_bop = hit(wb_req_i.adr, tpg_pkg::IDX_BIT_OP);
  assign hit_any = hit_nl | hit_nd | hit_nf | hit_wl | hit_wd | hit_dbg | hit_bop;

  // Single-bit operation fields
  wire [7:0]                 wdata;
  wire [2:0]                 bop_bit;
  wire                       bop_val;
  wire tpg_pkg::tpg_target_t bop_tgt;

  assign wdata   = wb_req_i.dat[7:0];
  assign bop_bit = wb_req_i.dat[tpg_pkg::BITOP_BIT_LSB +: 3];
  assign bop_val = wb_req_i.dat[tpg_pkg::BITOP_VAL_POS];
  assign bop_tgt = tpg_pkg::tpg_target_t'(wb_req_i.dat[tpg_pkg::BITOP_TGT_LSB +: 3]);
  // Needs both low lanes so the target and bit arrive together
  wire bop_lanes;
  assign bop_lanes = &wb_req_i.sel[1:0];
  assign bit_op_wr = commit & hit_bop & bop_lanes;

  // Per-register byte and bit strobes
  wire bw_nl;
  wire bw_nd;
  wire bw_nf;
  wire bw_wl;
  wire bw_wd;
  wire bb_nl;
  wire bb_nd;
  wire bb_nf;
  wire bb_wl;
  wire bb_wd;
  wire bb_dbg;

  assign bw_nl  = byte_wr & hit_nl;
  assign bw_nd  = byte_wr & hit_nd;
  assign bw_nf  = byte_wr & hit_nf;
  assign bw_wl  = byte_wr & hit_wl;
  assign bw_wd  = byte_wr & hit_wd;
  // (RULE9) single-bit access
  assign bb_nl  = bit_op_wr & (bop_tgt == tpg_pkg::TGT_NARROW_LATCH);
  assign bb_nd  = bit_op_wr & (bop_tgt == tpg_pkg::TGT_NARROW_DIR);
  assign bb_nf  = bit_op_wr & (bop_tgt == tpg_pkg::TGT_NARROW_FSEL);
  assign bb_wl  = bit_op_wr & (bop_tgt == tpg_pkg::TGT_WIDE_LATCH);
  assign bb_wd  = bit_op_wr & (bop_tgt == tpg_pkg::TGT_WIDE_DIR);
  assign bb_dbg = bit_op_wr & (bop_tgt == tpg_pkg::TGT_DEBUG);

  // Next register values
  wire [7:0] next_narrow_latch;
  wire [7:0] next_narrow_dir;
  wire [7:0] next_narrow_fsel;
  wire [7:0] next_wide_latch;
  wire [7:0] next_wide_dir;

  // (RULE1) writes reach the latch in either mode
  assign next_narrow_latch = upd(narrow_latch,
                                 bw_nl,
                                 wdata,
                                 bb_nl,
                                 bop_bit,
                                 bop_val,
                                 tpg_pkg::NARROW_MASK,
                                 tpg_pkg::ZERO_FIXED);

  // (RULE16) upper direction bits fixed at one
  assign next_narrow_dir   = upd(narrow_port_direction,
                                 bw_nd,
                                 wdata,
                                 bb_nd,
                                 bop_bit,
                                 bop_val,
                                 tpg_pkg::NARROW_MASK,
                                 tpg_pkg::DIR_FIXED);

  // (RULE16) only bit 1 is implemented
  assign next_narrow_fsel  = upd(narrow_port_function_select,
                                 bw_nf,
                                 wdata,
                                 bb_nf,
                                 bop_bit,
                                 bop_val,
                                 tpg_pkg::FSEL_MASK,
                                 tpg_pkg::ZERO_FIXED);

  // (RULE9) wide latch, every bit implemented
  assign next_wide_latch   = upd(wide_port_latch,
                                 bw_wl,
                                 wdata,
                                 bb_wl,
                                 bop_bit,
                                 bop_val,
                                 tpg_pkg::WIDE_MASK,
                                 tpg_pkg::ZERO_FIXED);

  // (RULE7) wide direction, every bit implemented
  assign next_wide_dir     = upd(wide_port_direction,
                                 bw_wd,
                                 wdata,
                                 bb_wd,
                                 bop_bit,
                                 bop_val,
                                 tpg_pkg::WIDE_MASK,
                                 tpg_pkg::ZERO_FIXED);

  // Debug-mode clear: only a written zero counts, a one is ignored
  wire dbg_clear;
  wire dbg_clear_byte;
  wire dbg_clear_bit;

  // (RULE11) software can only clear
  assign dbg_clear_byte = byte_wr & hit_dbg & ~wdata[tpg_pkg::DEBUG_MODE_BIT];
  assign dbg_clear_bit  = bb_dbg & (bop_bit == 3'(tpg_pkg::DEBUG_MODE_BIT)) & ~bop_val;
  assign dbg_clear      = dbg_clear_byte | dbg_clear_bit;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      // (RULE6) narrow latch cleared
      narrow_latch                <= tpg_pkg::RST_LATCH;
      // (RULE4) all inputs at reset
      narrow_port_direction       <= tpg_pkg::RST_DIR;
      // (RULE5) port function at reset
      narrow_port_function_select <= tpg_pkg::RST_FSEL;
      // (RULE8) wide latch cleared
      wide_port_latch             <= tpg_pkg::RST_LATCH;
      // (RULE7) wide port all inputs
      wide_port_direction         <= tpg_pkg::RST_DIR;
    end else begin
      // (RULE9) byte and bit writes land on the ack edge
      narrow_latch                <= next_narrow_latch;
      narrow_port_direction       <= next_narrow_dir;
      narrow_port_function_select <= next_narrow_fsel;
      wide_port_latch             <= next_wide_latch;
      wide_port_direction         <= next_wide_dir;
    end
  end

  // Clock output takes over pin 1 when selected
  wire [NARROW_W-1:0] narrow_alt_en;
  wire [NARROW_W-1:0] narrow_alt_val;
  wire [NARROW_W-1:0] narrow_rd;
  wire [WIDE_W-1:0]   wide_rd;
  wire                debug_mode;
  wire [NARROW_W-1:0] clk_pin_mask;
  wire                clk_sel;

  // Shift at port width so the select bit cannot fall off a one-bit shift
  assign clk_pin_mask   = NARROW_W'(1) << tpg_pkg::FSEL_CLK_BIT;
  assign clk_sel        = narrow_port_function_select[tpg_pkg::FSEL_CLK_BIT];
  // (RULE5) pin 1 clock routing
  assign narrow_alt_en  = {NARROW_W{clk_sel}} & clk_pin_mask;
  assign narrow_alt_val = {NARROW_W{clock_output_function_i}} & clk_pin_mask;

  // (RULE3) (RULE4) narrow pins, bit by bit
  tpg_port #(
    .W (NARROW_W)
  ) u_narrow (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .latch_i   (narrow_latch[NARROW_W-1:0]),
    .dir_i     (narrow_port_direction[NARROW_W-1:0]),
    .alt_en_i  (narrow_alt_en),
    .alt_val_i (narrow_alt_val),
    .pin_i     (narrow_pin_i),
    .pin_o     (narrow_pin_o),
    .pin_oe_o  (narrow_pin_oe_o),
    .rd_o      (narrow_rd)
  );

  // Wide pin 5 is left to the flash logic outside in programming mode
  // (RULE7) eight pins, same direction coding
  tpg_port #(
    .W (WIDE_W)
  ) u_wide (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .latch_i   (wide_port_latch[WIDE_W-1:0]),
    .dir_i     (wide_port_direction[WIDE_W-1:0]),
    .alt_en_i  ('0),
    .alt_val_i ('0),
    .pin_i     (wide_pin_i),
    .pin_o     (wide_pin_o),
    .pin_oe_o  (wide_pin_oe_o),
    .rd_o      (wide_rd)
  );

  // (RULE10) (RULE13) debug pins and pull-down from reset
  tpg_debug u_debug (
    .clk_i         (clk_i),
    .rst_i         (rst_i),
    .clear_i       (dbg_clear),
    .mode_o        (debug_mode),
    .sel_o         (debug_pins_sel_o),
    .pulldown_en_o (debug_reset_pulldown_en_o)
  );

  // Read-back mux; unmapped and bit-op addresses read zero
  logic [31:0] next_rdata;
  wire  [31:0] debug_word;

  // Mode bit placed at its field position
  assign debug_word = 32'(debug_mode) << tpg_pkg::DEBUG_MODE_BIT;

  // (RULE1) (RULE2) mode-dependent read-back
  always_comb begin
    next_rdata = 32'h00000000;
    if (hit_nl) begin
      next_rdata = 32'(narrow_rd);
    end else if (hit_nd) begin
      next_rdata = 32'(narrow_port_direction);
    end else if (hit_nf) begin
      next_rdata = 32'(narrow_port_function_select);
    end else if (hit_wl) begin
      next_rdata = 32'(wide_rd);
    end else if (hit_wd) begin
      next_rdata = 32'(wide_port_direction);
    end else if (hit_dbg) begin
      next_rdata = debug_word;
    end
  end

  // Read data captured at the taking edge
  wire rd_capture;

  assign rd_capture = take & ~wb_req_i.we & hit_any;

  // Every address is answered so the master never hangs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= take;
      if (rd_capture) begin
        wb_dat_o <= next_rdata;
      end else if (take) begin
        wb_dat_o <= 32'h00000000;
      end
    end
  end

endmodule
`default_nettype wire

// File: tpg_gpio_chk.sv
// Bus and pin assertions for the two-port GPIO
`timescale 1ns/1ps
`default_nettype none
module tpg_gpio_chk #(
  parameter int unsigned NARROW_W = 2,
  parameter int unsigned WIDE_W   = 8
) (
  input wire logic                 clk_i,
  input wire logic                 rst_i,
  input wire tpg_pkg::tpg_wb_req_t wb_req_i,
  input wire logic [31:0]          wb_dat_o,
  input wire logic                 wb_ack_o,
  input wire logic [NARROW_W-1:0]  narrow_pin_oe_o,
  input wire logic [WIDE_W-1:0]    wide_pin_i,
  input wire logic [WIDE_W-1:0]    wide_pin_o,
  input wire logic [WIDE_W-1:0]    wide_pin_oe_o,
  input wire logic                 debug_pins_sel_o,
  input wire logic                 debug_reset_pulldown_en_o
);
  localparam logic [31:0] A_WL = tpg_pkg::IDX_WIDE_LATCH << 2;
  localparam logic [31:0] A_WD = tpg_pkg::IDX_WIDE_DIR << 2;
  localparam logic [31:0] A_ND = tpg_pkg::IDX_NARROW_DIR << 2;
  localparam logic [31:0] A_NF = tpg_pkg::IDX_NARROW_FSEL << 2;
  localparam logic [31:0] A_DM = tpg_pkg::IDX_DEBUG_MODE << 2;
  wire tk = wb_req_i.cyc && wb_req_i.stb && !wb_ack_o;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Taken request then its ack; pins settle two edges later
  sequence wr_s(a);
    tk && wb_req_i.we && wb_req_i.sel[0] && wb_req_i.adr == a ##1 wb_ack_o;
  endsequence
  sequence rd_s(a);
    tk && !wb_req_i.we && wb_req_i.adr == a ##1 wb_ack_o;
  endsequence
  ack_after_take_a: assert property (tk |=> wb_ack_o)
    else $error("ack missing after request");
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  reset_state_a: assert property (disable iff (1'b0) rst_i |=> (narrow_pin_oe_o == '0 &&
    wide_pin_oe_o == '0 && debug_pins_sel_o && debug_reset_pulldown_en_o))
    else $error("pin state wrong after reset");
  wide_dir_oe_a: assert property (wr_s(A_WD) |-> ##2
    wide_pin_oe_o == ~$past(wb_req_i.dat[7:0], 3))
    else $error("wide enable does not follow direction");
  wide_latch_out_a: assert property (wr_s(A_WL) |-> ##2
    wide_pin_o == $past(wb_req_i.dat[7:0], 3))
    else $error("wide drive does not follow latch");
  narrow_dir_oe_a: assert property (wr_s(A_ND) |-> ##2
    narrow_pin_oe_o[0] == !$past(wb_req_i.dat[0], 3))
    else $error("narrow enable does not follow direction");
  clk_route_a: assert property (wr_s(A_NF) ##0 wb_req_i.dat[1] |-> ##2 narrow_pin_oe_o[1])
    else $error("pin1 not driven in clock mode");
  debug_clear_a: assert property (wr_s(A_DM) ##0 !wb_req_i.dat[0] |-> ##[1:2] !debug_pins_sel_o)
    else $error("debug pins not released");
  debug_hold_a: assert property (!debug_pins_sel_o |=> !debug_pins_sel_o)
    else $error("debug pins reclaimed without reset");
  pulldown_track_a: assert property (debug_reset_pulldown_en_o == debug_pins_sel_o)
    else $error("pull-down not tied to debug mode");
  read_mix_a: assert property (rd_s(A_WL) |-> wb_dat_o[7:0] ==
    (($past(wide_pin_i) & ~$past(wide_pin_oe_o)) | ($past(wide_pin_o) & $past(wide_pin_oe_o))))
    else $error("wide read mixes pins and latch wrongly");
  dir_fixed_a: assert property (rd_s(A_ND) |-> wb_dat_o[7:2] == 6'h3F)
    else $error("narrow direction upper bits not one");
endmodule
bind tpg_gpio tpg_gpio_chk #(.NARROW_W(NARROW_W), .WIDE_W(WIDE_W)) u_chk (.clk_i, .rst_i,
  .wb_req_i, .wb_dat_o, .wb_ack_o, .narrow_pin_oe_o, .wide_pin_i, .wide_pin_o,
  .wide_pin_oe_o, .debug_pins_sel_o, .debug_reset_pulldown_en_o);
`default_nettype wire

// File: tpg_board.sv
// Board side of a port: drives pins where the block does not
`timescale 1ns/1ps
`default_nettype none
module tpg_board #(
  parameter int unsigned W = 8
) (
  input  wire logic [W-1:0] pin_o,
  input  wire logic [W-1:0] oe,
  input  wire logic [W-1:0] ext,
  output wire logic [W-1:0] pin_i,
  output wire logic         debug_reset_level_o
);
  // flash select on wide pin 5 comes from the board level, not registers
  // Block wins where enabled, else the board level
  assign pin_i = (oe & pin_o) | (~oe & ext);
  assign debug_reset_level_o = 1'b0;
endmodule
`default_nettype wire

// File: tpg_gpio_test.sv
// Directed register and pin tests for the two-port GPIO
`timescale 1ns/1ps
`default_nettype none
module tpg_gpio_test;
  localparam logic [31:0] A_WL = tpg_pkg::IDX_WIDE_LATCH << 2;
  localparam logic [31:0] A_WD = tpg_pkg::IDX_WIDE_DIR << 2;
  localparam logic [31:0] A_ND = tpg_pkg::IDX_NARROW_DIR << 2;
  localparam logic [31:0] A_NF = tpg_pkg::IDX_NARROW_FSEL << 2;
  localparam logic [31:0] A_NL = tpg_pkg::IDX_NARROW_LATCH << 2;
  localparam logic [31:0] A_DM = tpg_pkg::IDX_DEBUG_MODE << 2;
  localparam logic [31:0] A_BO = tpg_pkg::IDX_BIT_OP << 2;
  logic                 clk_i, rst_i, clk_src, ack, dsel, pden;
  tpg_pkg::tpg_wb_req_t req;
  logic [31:0]          rdat, q;
  logic [1:0]           n_in, n_out, n_oe, n_ext;
  logic [7:0]           w_in, w_out, w_oe, w_ext;
  int                   n_mismatch, total_checks, cyc_cnt;
  // Bit-op table: target address, value in bit3 and bit number, result
  logic [31:0]          ta [5] = '{A_NL, A_ND, A_NF, A_WL, A_WD};
  logic [3:0]           tv [5] = '{4'h0, 4'h9, 4'h9, 4'hF, 4'hB};
  logic [7:0]           te [5] = '{8'h02, 8'hFE, 8'h02, 8'hDA, 8'h08};
  tpg_gpio u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_dat_o(rdat),
    .wb_ack_o(ack), .narrow_pin_i(n_in), .narrow_pin_o(n_out), .narrow_pin_oe_o(n_oe),
    .clock_output_function_i(clk_src), .wide_pin_i(w_in), .wide_pin_o(w_out),
    .wide_pin_oe_o(w_oe), .debug_pins_sel_o(dsel), .debug_reset_pulldown_en_o(pden));
  tpg_board #(.W(2)) u_nb (.pin_o(n_out), .oe(n_oe), .ext(n_ext), .pin_i(n_in),
    .debug_reset_level_o());
  tpg_board #(.W(8)) u_wb (.pin_o(w_out), .oe(w_oe), .ext(w_ext), .pin_i(w_in),
    .debug_reset_level_o());
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task print_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Well beyond the directed sequence
  always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 3000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  task chk(input logic [31:0] g, input logic [31:0] e, input string m);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  // Request held until ack is sampled, then one idle cycle
  task bus(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    req <= '{cyc: 1'b1, stb: 1'b1, we: w, sel: s, adr: a, dat: d};
    @(posedge clk_i);
    while (ack !== 1'b1 && n < 20) begin
      n++;
      @(posedge clk_i);
    end
    if (n == 20) chk(32'h0, 32'h1, "no ack");
    q = rdat;
    req <= '0;
    @(posedge clk_i);
  endtask
  task wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s = 4'h1);
    bus(1'b1, a, d, s);
  endtask
  task rd(input logic [31:0] a);
    bus(1'b0, a, 32'h0, 4'h1);
  endtask
  task reset_dut;
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
  endtask
  initial begin
    rst_i = 1'b1;
    req = '0;
    clk_src = 1'b0;
    n_ext = 2'b10;
    w_ext = 8'hA5;
    n_mismatch = 0;
    total_checks = 0;
    cyc_cnt = 0;
    reset_dut();
    chk(32'({w_oe, n_oe, dsel, pden}), 32'h3, "reset pins");
    rd(A_ND); chk(q, 32'hFF, "narrow dir");
    rd(A_NF); chk(q, 32'h0, "fsel");
    rd(A_WD); chk(q, 32'hFF, "wide dir");
    rd(A_DM); chk(q, 32'h1, "debug mode");
    rd(32'h10); chk(q, 32'h0, "unmapped");
    rd(A_NL); chk(q, 32'h2, "narrow in");
    rd(A_WL); chk(q, 32'hA5, "wide in");
    $display("test reset done");
    wr(A_WD, 32'h0); rd(A_WL); chk(q, 32'h0, "wide reset latch");
    wr(A_WL, 32'h3C); @(posedge clk_i); chk(32'({w_out, w_oe}), 32'h3CFF, "wide out");
    wr(A_WD, 32'hF0); rd(A_WL); chk(q, 32'hAC, "wide mixed");
    wr(A_WD, 32'hFF); wr(A_WL, 32'h5A); rd(A_WL); chk(q, 32'hA5, "wide in wr");
    wr(A_WD, 32'h0); rd(A_WL); chk(q, 32'h5A, "wide latched");
    $display("test wide done");
    wr(A_ND, 32'h0); rd(A_ND); chk(q, 32'hFC, "narrow fixed");
    chk(32'(n_oe), 32'h3, "narrow oe");
    rd(A_NL); chk(q, 32'h0, "narrow reset latch");
    wr(A_NL, 32'hFF); rd(A_NL); chk(q, 32'h3, "narrow latch");
    chk(32'(n_out), 32'h3, "narrow out");
    wr(A_NF, 32'hFF); rd(A_NF); chk(q, 32'h2, "fsel fixed");
    repeat (3) @(posedge clk_i);
    chk(32'(n_out[1]), 32'h0, "clock low");
    clk_src <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk(32'({n_out[1], n_oe[1]}), 32'h3, "clock high");
    clk_src <= 1'b0;
    wr(A_NF, 32'h0); @(posedge clk_i); chk(32'(n_out[1]), 32'h1, "port back");
    $display("test narrow done");
    for (int i = 0; i < 5; i++) begin
      wr(A_BO, {21'h0, 3'(i), 3'h0, tv[i][3], 1'b0, tv[i][2:0]}, 4'h3);
      rd(ta[i]); chk(q, {24'h0, te[i]}, "bit op");
    end
    wr(A_WD, 32'h0, 4'h2); wr(A_BO, 32'h403, 4'h1);
    rd(A_WD); chk(q, 32'h08, "lanes ignored");
    rd(A_BO); chk(q, 32'h0, "bitop reads zero");
    $display("test bitop done");
    wr(A_DM, 32'h1); @(posedge clk_i); chk(32'(dsel), 32'h1, "debug kept");
    wr(A_DM, 32'h0); @(posedge clk_i); chk(32'({dsel, pden}), 32'h0, "debug off");
    reset_dut(); chk(32'({dsel, pden}), 32'h3, "debug again");
    wr(A_BO, 32'h500, 4'h3); @(posedge clk_i); chk(32'(dsel), 32'h0, "debug bit");
    $display("test debug done");
    print_verdict();
  end
endmodule
`default_nettype wire
